//--- rtl/arv_verify.sv
// verify-sectors command handler inside the drive task file
`timescale 1ns/1ns
module arv_verify
(
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 rstn,
  // register port
  input  wire logic [3:0]           regAddr,
  input  wire logic [7:0]           regWdata,
  input  wire logic                 regWr,
  input  wire logic                 regRd,
  output logic      [7:0]           regRdata,
  // host data path
  output logic      [15:0]          hostData,
  output logic                      hostDataValid,
  // media read channel
  output arv_pkg::arv_media_req_t   mediaReq,
  input  wire logic                 mediaAck,
  input  wire logic                 mediaFail,
  // interrupt
  output logic                      irq
);
  //////////////////////////////////////////////////////////////////////////////
  // state
  arv_pkg::arv_state_t state_q, state_d;
  logic [7:0]  cntCur_q, cntCur_d, cntPrv_q, cntPrv_d;
  logic [7:0]  snCur_q, snCur_d, snPrv_q, snPrv_d;
  logic [7:0]  clCur_q, clCur_d, clPrv_q, clPrv_d;
  logic [7:0]  chCur_q, chCur_d, chPrv_q, chPrv_d;
  logic [7:0]  devHead_q, devHead_d;
  logic [7:0]  status_q, status_d;
  logic [7:0]  error_q, error_d;
  logic [7:0]  ctrl_q, ctrl_d;
  logic [1:0]  irqStat_q, irqStat_d, irqEn_q, irqEn_d;
  logic [16:0] left_q, left_d;
  logic [47:0] addr_q, addr_d;
  logic        ext_q, ext_d, lba_q, lba_d, reqOut_q, reqOut_d;
  logic [7:0]  rdata_q, rdata_d;
  logic        isCmdWr, isVerify;
  logic [1:0]  irqSet;

  assign isCmdWr  = regWr && (regAddr == arv_pkg::OFF_CMDSTAT) && !status_q[arv_pkg::ST_BSY];
  // retry bit is opcode bit 0 and is not looked at beyond opcode match
  assign isVerify = (regWdata == arv_pkg::CMD_VERIFY) || (regWdata == arv_pkg::CMD_VERIFY_NR)
                 || (regWdata == arv_pkg::CMD_VERIFY_EXT);

  //////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb
  begin
    state_d   = state_q;
    cntCur_d  = cntCur_q;
    cntPrv_d  = cntPrv_q;
    snCur_d   = snCur_q;
    snPrv_d   = snPrv_q;
    clCur_d   = clCur_q;
    clPrv_d   = clPrv_q;
    chCur_d   = chCur_q;
    chPrv_d   = chPrv_q;
    devHead_d = devHead_q;
    status_d  = status_q;
    error_d   = error_q;
    ctrl_d    = ctrl_q;
    irqEn_d   = irqEn_q;
    left_d    = left_q;
    addr_d    = addr_q;
    ext_d     = ext_q;
    lba_d     = lba_q;
    reqOut_d  = reqOut_q;
    irqSet    = 2'b00;
    if (regWr && !status_q[arv_pkg::ST_BSY])
    begin
      // extended form: each count, sector or cylinder write shifts current byte into previous
      case (regAddr)
        arv_pkg::OFF_SECCNT:  begin cntPrv_d = cntCur_q; cntCur_d = regWdata; end
        arv_pkg::OFF_SECNUM:  begin snPrv_d  = snCur_q;  snCur_d  = regWdata; end
        arv_pkg::OFF_CYLLO:   begin clPrv_d  = clCur_q;  clCur_d  = regWdata; end
        arv_pkg::OFF_CYLHI:   begin chPrv_d  = chCur_q;  chCur_d  = regWdata; end
        arv_pkg::OFF_DEVHEAD: devHead_d = regWdata;
        arv_pkg::OFF_IRQEN:   irqEn_d   = regWdata[1:0];
        arv_pkg::OFF_CTRL:    ctrl_d    = regWdata;
        default: ;
      endcase
    end
    case (state_q)
      arv_pkg::ST_IDLE:
      begin
        if (isCmdWr && isVerify)
        begin
          ext_d = (regWdata == arv_pkg::CMD_VERIFY_EXT);
          error_d = 8'h00;
          status_d[arv_pkg::ST_BSY] = 1'b1;
          status_d[arv_pkg::ST_ERR] = 1'b0;
          if (regWdata == arv_pkg::CMD_VERIFY_EXT)
          begin
            lba_d  = 1'b1;
            addr_d = {chPrv_q, clPrv_q, snPrv_q, chCur_q, clCur_q, snCur_q};
            left_d = ({cntPrv_q, cntCur_q} == 16'h0000) ? arv_pkg::CNT_ZERO48
                   : {1'b0, cntPrv_q, cntCur_q};
          end
          else
          begin
            lba_d  = devHead_q[arv_pkg::DH_LBA];
            addr_d = {20'h00000, devHead_q[3:0], chCur_q, clCur_q, snCur_q};
            left_d = (cntCur_q == 8'h00) ? arv_pkg::CNT_ZERO28
                   : {9'h000, cntCur_q};
          end
          reqOut_d = 1'b1;
          state_d  = arv_pkg::ST_CHECK;
        end
      end
      arv_pkg::ST_CHECK:
      begin
        if (mediaAck)
        begin
          reqOut_d = 1'b0;
          if (mediaFail)
          begin
            // failing sector is the last processed; it stays counted as not verified
            error_d[arv_pkg::ER_UNCORRECTABLE] = 1'b1;
            status_d[arv_pkg::ST_ERR] = 1'b1;
            state_d = arv_pkg::ST_DONE;
          end
          else
          begin
            left_d = left_q - 17'h00001;
            if (left_q == 17'h00001)
              state_d = arv_pkg::ST_DONE;
            else
            begin
              reqOut_d = 1'b1;
              if (lba_q)
                addr_d = addr_q + 48'h000000000001;
              // geometry walk: sectors 1..255 per track, 16 heads, a simplified layout
              else if (addr_q[7:0] == 8'hff)
              begin
                addr_d[7:0] = 8'h01;
                if (addr_q[27:24] == 4'hf)
                begin
                  addr_d[27:24] = 4'h0;
                  addr_d[23:8]  = addr_q[23:8] + 16'h0001;
                end
                else
                  addr_d[27:24] = addr_q[27:24] + 4'h1;
              end
              else
                addr_d[7:0] = addr_q[7:0] + 8'h01;
            end
          end
          // write back last processed location in the input layout
          snCur_d = addr_q[7:0];
          clCur_d = addr_q[15:8];
          chCur_d = addr_q[23:16];
          if (ext_q)
          begin
            snPrv_d = addr_q[31:24];
            clPrv_d = addr_q[39:32];
            chPrv_d = addr_q[47:40];
          end
          else
            devHead_d[3:0] = addr_q[27:24];
        end
      end
      arv_pkg::ST_DONE:
      begin
        cntCur_d = left_d[7:0];
        cntPrv_d = ext_q ? left_q[15:8] : cntPrv_q;
        status_d[arv_pkg::ST_BSY] = 1'b0;
        status_d[arv_pkg::ST_RDY] = 1'b1;
        irqSet[arv_pkg::IRQ_DONE] = 1'b1;
        irqSet[arv_pkg::IRQ_FAIL] = error_q[arv_pkg::ER_UNCORRECTABLE];
        state_d = arv_pkg::ST_IDLE;
      end
      default: state_d = arv_pkg::ST_IDLE;
    endcase
  end

  // sticky interrupt status: a set in the clear cycle wins
  always_comb
  begin
    irqStat_d = irqStat_q;
    if (regWr && (regAddr == arv_pkg::OFF_IRQCLR))
      irqStat_d = irqStat_q & ~regWdata[1:0];
    irqStat_d = irqStat_d | irqSet;
  end

  // read mux; hob selects previous bytes of the extended pair
  always_comb
  begin
    rdata_d = 8'h00;
    if (regRd)
    begin
      case (regAddr)
        arv_pkg::OFF_ERRFEAT: rdata_d = error_q;
        arv_pkg::OFF_SECCNT:  rdata_d = ctrl_q[arv_pkg::CT_HOB] ? cntPrv_q : cntCur_q;
        arv_pkg::OFF_SECNUM:  rdata_d = ctrl_q[arv_pkg::CT_HOB] ? snPrv_q  : snCur_q;
        arv_pkg::OFF_CYLLO:   rdata_d = ctrl_q[arv_pkg::CT_HOB] ? clPrv_q  : clCur_q;
        arv_pkg::OFF_CYLHI:   rdata_d = ctrl_q[arv_pkg::CT_HOB] ? chPrv_q  : chCur_q;
        arv_pkg::OFF_DEVHEAD: rdata_d = devHead_q;
        arv_pkg::OFF_CMDSTAT: rdata_d = status_q;
        arv_pkg::OFF_IRQSTAT: rdata_d = {6'h00, irqStat_q};
        arv_pkg::OFF_IRQEN:   rdata_d = {6'h00, irqEn_q};
        arv_pkg::OFF_CTRL:    rdata_d = ctrl_q;
        default:              rdata_d = 8'h00;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      state_q   <= arv_pkg::ST_IDLE;
      cntCur_q  <= arv_pkg::CNT_RST;
      cntPrv_q  <= 8'h00;
      snCur_q   <= arv_pkg::SECNUM_RST;
      snPrv_q   <= 8'h00;
      clCur_q   <= 8'h00;
      clPrv_q   <= 8'h00;
      chCur_q   <= 8'h00;
      chPrv_q   <= 8'h00;
      devHead_q <= arv_pkg::DEVHEAD_RST;
      status_q  <= arv_pkg::STATUS_RST;
      error_q   <= 8'h00;
      ctrl_q    <= 8'h00;
      irqStat_q <= 2'b00;
      irqEn_q   <= 2'b00;
      left_q    <= 17'h00000;
      addr_q    <= 48'h000000000000;
      ext_q     <= 1'b0;
      lba_q     <= 1'b0;
      reqOut_q  <= 1'b0;
      rdata_q   <= 8'h00;
    end
    else
    begin
      state_q   <= state_d;
      cntCur_q  <= cntCur_d;
      cntPrv_q  <= cntPrv_d;
      snCur_q   <= snCur_d;
      snPrv_q   <= snPrv_d;
      clCur_q   <= clCur_d;
      clPrv_q   <= clPrv_d;
      chCur_q   <= chCur_d;
      chPrv_q   <= chPrv_d;
      devHead_q <= devHead_d;
      status_q  <= status_d;
      error_q   <= error_d;
      ctrl_q    <= ctrl_d;
      irqStat_q <= irqStat_d;
      irqEn_q   <= irqEn_d;
      left_q    <= left_d;
      addr_q    <= addr_d;
      ext_q     <= ext_d;
      lba_q     <= lba_d;
      reqOut_q  <= reqOut_d;
      rdata_q   <= rdata_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs
  assign regRdata         = rdata_q;
  assign hostData         = 16'h0000;
  assign hostDataValid    = 1'b0;
  assign mediaReq         = '{valid: reqOut_q, lba: addr_q, head: addr_q[27:24],
                              cyl: addr_q[23:8], sec: addr_q[7:0], lbaMode: lba_q};
  assign irq              = |(irqStat_q & irqEn_q);

  //////////////////////////////////////////////////////////////////////////////
  // assertions
  property p_opcode_start;
    @(posedge clk) disable iff (!rstn)
      (isCmdWr && isVerify && state_q == arv_pkg::ST_IDLE)
      |=> (state_q == arv_pkg::ST_CHECK) && status_q[arv_pkg::ST_BSY];
  endproperty
  a_opcode_start: assert property (p_opcode_start) else $error("verify opcode not started");
  property p_no_data;
    @(posedge clk) disable iff (!rstn) !hostDataValid;
  endproperty
  a_no_data: assert property (p_no_data) else $error("data placed on host path");
  property p_stop_fail;
    @(posedge clk) disable iff (!rstn)
      (state_q == arv_pkg::ST_CHECK && mediaAck && mediaFail)
      |=> !mediaReq.valid ##1 !status_q[arv_pkg::ST_BSY];
  endproperty
  a_stop_fail: assert property (p_stop_fail) else $error("verify went past a bad sector");
  property p_zero_cnt;
    @(posedge clk) disable iff (!rstn)
      (isCmdWr && state_q == arv_pkg::ST_IDLE && regWdata == arv_pkg::CMD_VERIFY
       && cntCur_q == 8'h00) |=> (left_q == 17'h00100);
  endproperty
  a_zero_cnt: assert property (p_zero_cnt) else $error("zero count not 256");
  property p_ext_lba;
    @(posedge clk) disable iff (!rstn)
      (isCmdWr && state_q == arv_pkg::ST_IDLE && regWdata == arv_pkg::CMD_VERIFY_EXT)
      |=> lba_q && (addr_q[47:40] == $past(chPrv_q));
  endproperty
  a_ext_lba: assert property (p_ext_lba) else $error("extended address wrong");
  property p_good_left;
    @(posedge clk) disable iff (!rstn)
      (state_q == arv_pkg::ST_DONE && !error_q[arv_pkg::ER_UNCORRECTABLE])
      |=> (cntCur_q == 8'h00);
  endproperty
  a_good_left: assert property (p_good_left) else $error("count left not zero");
  property p_last_addr;
    @(posedge clk) disable iff (!rstn)
      (state_q == arv_pkg::ST_CHECK && mediaAck) |=> (snCur_q == $past(addr_q[7:0]));
  endproperty
  a_last_addr: assert property (p_last_addr) else $error("last sector not reported");
  property p_done_status;
    @(posedge clk) disable iff (!rstn)
      (state_q == arv_pkg::ST_DONE) |=> !status_q[arv_pkg::ST_BSY] && status_q[arv_pkg::ST_RDY]
      && (status_q[arv_pkg::ST_ERR] == error_q[arv_pkg::ER_UNCORRECTABLE]);
  endproperty
  a_done_status: assert property (p_done_status) else $error("completion status wrong");

  c_ext: cover property (@(posedge clk) disable iff (!rstn)
    isCmdWr && regWdata == arv_pkg::CMD_VERIFY_EXT);
  c_fail: cover property (@(posedge clk) disable iff (!rstn)
    state_q == arv_pkg::ST_CHECK && mediaAck && mediaFail);
  c_irq: cover property (@(posedge clk) disable iff (!rstn) irq);
endmodule // arv_verify

//--- rtl/arv_pkg.sv
// package: task-file offsets, field layouts, opcodes, states and resets of the verify handler
package arv_pkg;
  // task-file register indices (byte offsets on the plain port)
  localparam logic [3:0] OFF_DATA    = 4'h0;
  localparam logic [3:0] OFF_ERRFEAT = 4'h1;
  localparam logic [3:0] OFF_SECCNT  = 4'h2;
  localparam logic [3:0] OFF_SECNUM  = 4'h3;
  localparam logic [3:0] OFF_CYLLO   = 4'h4;
  localparam logic [3:0] OFF_CYLHI   = 4'h5;
  localparam logic [3:0] OFF_DEVHEAD = 4'h6;
  localparam logic [3:0] OFF_CMDSTAT = 4'h7;
  localparam logic [3:0] OFF_IRQSTAT = 4'h8;
  localparam logic [3:0] OFF_IRQCLR  = 4'h9;
  localparam logic [3:0] OFF_IRQEN   = 4'ha;
  localparam logic [3:0] OFF_CTRL    = 4'hb;
  // opcodes
  localparam logic [7:0] CMD_VERIFY     = 8'h40;
  localparam logic [7:0] CMD_VERIFY_NR  = 8'h41;
  localparam logic [7:0] CMD_VERIFY_EXT = 8'h42;
  // status bit positions
  localparam int ST_BSY = 7;
  localparam int ST_RDY = 6;
  localparam int ST_DEVFAULT = 5;
  localparam int ST_DSC = 4;
  localparam int ST_ERR = 0;
  // error register bit
  localparam int ER_UNCORRECTABLE = 6;
  // device/head fields
  localparam int DH_LBA = 6;
  localparam int DH_DEV = 4;
  // ctrl register: bit 7 selects high-order byte readback
  localparam int CT_HOB = 7;
  // interrupt bits
  localparam int IRQ_DONE = 0;
  localparam int IRQ_FAIL = 1;
  // reset values
  localparam logic [7:0] STATUS_RST  = 8'h50;
  localparam logic [7:0] DEVHEAD_RST = 8'ha0;
  localparam logic [7:0] CNT_RST     = 8'h01;
  localparam logic [7:0] SECNUM_RST  = 8'h01;
  // count for a zero count in the 28-bit and 48-bit forms
  localparam logic [16:0] CNT_ZERO28 = 17'h00100;
  localparam logic [16:0] CNT_ZERO48 = 17'h10000;

  typedef enum logic [2:0]
  {
    ST_IDLE  = 3'b001,
    ST_CHECK = 3'b010,
    ST_DONE  = 3'b100
  } arv_state_t;

  // one media check request towards the read channel
  typedef struct packed
  {
    logic        valid;
    logic [47:0] lba;
    logic [3:0]  head;
    logic [15:0] cyl;
    logic [7:0]  sec;
    logic        lbaMode;
  } arv_media_req_t;
endpackage

//--- dv/arv_media_model.sv
// media read channel model answering the verify handler's sector checks
`timescale 1ns/1ns
module arv_media_model
(
  // clock and reset
  input  wire logic                     clk,
  input  wire logic                     rstn,
  // request from the handler
  input  wire arv_pkg::arv_media_req_t  mediaReq,
  output logic                          mediaAck,
  output logic                          mediaFail,
  // scenario control
  input  wire logic                     slow,
  input  wire logic                     failEn,
  input  wire logic [47:0]              failLba,
  output int                            ackCount,
  output arv_pkg::arv_media_req_t       lastReq
);
  logic [2:0] waitQ;
  logic       holdQ;
  logic       failQ;
  logic       toggleQ;

  // fail only means something beside ack; elsewhere it wobbles so nothing leans on it
  assign mediaFail = mediaAck ? failQ : toggleQ;

  always @(posedge clk)
  begin
    toggleQ <= ~toggleQ;
    if (!rstn)
    begin
      toggleQ  <= 1'b0;
      mediaAck <= 1'b0;
      failQ    <= 1'b0;
      holdQ    <= 1'b0;
      waitQ    <= 3'd0;
      ackCount <= 0;
    end
    else if (mediaAck || holdQ)
    begin
      // skip a cycle so a request still shown just after ack is not answered twice
      mediaAck <= 1'b0;
      holdQ    <= mediaAck;
      waitQ    <= 3'd0;
    end
    else if (mediaReq.valid)
    begin
      if (waitQ >= (slow ? 3'd4 : 3'd1))
      begin
        mediaAck <= 1'b1;
        failQ    <= failEn && (mediaReq.lba == failLba);
        ackCount <= ackCount + 1;
        lastReq  <= mediaReq;
      end
      else
        waitQ <= waitQ + 3'd1;
    end
    else
      waitQ <= 3'd0;
  end
endmodule // arv_media_model

//--- dv/test_arv_verify.sv
// testbench for the verify-sectors command handler
`timescale 1ns/1ns
module test_arv_verify;
  logic                    clk      = 1'b0;
  logic                    rstn     = 1'b0;
  logic [3:0]              regAddr  = 4'h0;
  logic [7:0]              regWdata = 8'h00;
  logic                    regWr    = 1'b0;
  logic                    regRd    = 1'b0;
  logic [7:0]              regRdata;
  logic [15:0]             hostData;
  logic                    hostDataValid;
  arv_pkg::arv_media_req_t mediaReq;
  arv_pkg::arv_media_req_t lastReq;
  logic                    mediaAck;
  logic                    mediaFail;
  logic                    irq;
  logic                    slow     = 1'b0;
  logic                    failEn   = 1'b0;
  logic [47:0]             failLba  = 48'h0;
  logic                    dataSeen = 1'b0;
  logic [7:0]              rv;
  int                      ackCount;
  int                      n0;
  int                      num_errors = 0;
  int                      tests_run  = 0;

  always #2 clk = ~clk;

  arv_verify arv_verify_inst
  (
    .clk(clk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .hostData(hostData),
    .hostDataValid(hostDataValid), .mediaReq(mediaReq), .mediaAck(mediaAck),
    .mediaFail(mediaFail), .irq(irq)
  );

  arv_media_model arv_media_model_inst
  (
    .clk(clk), .rstn(rstn), .mediaReq(mediaReq), .mediaAck(mediaAck), .mediaFail(mediaFail),
    .slow(slow), .failEn(failEn), .failLba(failLba), .ackCount(ackCount), .lastReq(lastReq)
  );

  // any sector data on the host path is latched here for a later check
  always @(posedge clk)
    if (hostDataValid !== 1'b0 || hostData !== 16'h0000)
      dataSeen <= 1'b1;

  //////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test;
    $display("compares %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge clk);
    regWr    <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge clk);
    regRd   <= 1'b0;
    #1 d = regRdata;
  endtask

  task automatic rdc(input logic [3:0] a, input logic [7:0] e);
    rd(a, rv);
    chk(48'(rv), 48'(e));
  endtask

  task automatic wait_done;
    int i;
    for (i = 0; i < 3000; i++)
    begin
      rd(arv_pkg::OFF_CMDSTAT, rv);
      if (rv[7] === 1'b0)
        break;
    end
    if (i == 3000)
      chk(48'h1, 48'h0);
  endtask

  task automatic run28(input logic [7:0] op, dh, cnt, sn, cl, ch);
    n0 = ackCount;
    wr(arv_pkg::OFF_SECCNT, cnt);
    wr(arv_pkg::OFF_SECNUM, sn);
    wr(arv_pkg::OFF_CYLLO, cl);
    wr(arv_pkg::OFF_CYLHI, ch);
    wr(arv_pkg::OFF_DEVHEAD, dh);
    wr(arv_pkg::OFF_CMDSTAT, op);
    wait_done();
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #100000;
    num_errors++;
    end_of_test();
  end

  initial
  begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    rdc(arv_pkg::OFF_CMDSTAT, arv_pkg::STATUS_RST);
    rdc(arv_pkg::OFF_DEVHEAD, arv_pkg::DEVHEAD_RST);
    rdc(arv_pkg::OFF_SECCNT, arv_pkg::CNT_RST);
    rdc(4'hc, 8'h00);
    chk(48'(irq), 48'h0);
    $display("test reset values done");
    // both 28-bit opcodes, second one against a slow channel; start crosses a byte edge
    for (int k = 0; k < 2; k++)
    begin
      slow <= k[0];
      run28(k ? arv_pkg::CMD_VERIFY_NR : arv_pkg::CMD_VERIFY, 8'he1, 8'h03, 8'hfe, 8'h34, 8'h12);
      chk(48'(ackCount - n0), 48'd3);
      chk(lastReq.lba, 48'h0000_0112_3500);
      rdc(arv_pkg::OFF_SECNUM, 8'h00);
      rdc(arv_pkg::OFF_CYLLO, 8'h35);
      rdc(arv_pkg::OFF_CYLHI, 8'h12);
      rdc(arv_pkg::OFF_DEVHEAD, 8'he1);
      rdc(arv_pkg::OFF_SECCNT, 8'h00);
      rdc(arv_pkg::OFF_CMDSTAT, 8'h50);
      rd(arv_pkg::OFF_IRQSTAT, rv);
      chk(48'(rv[arv_pkg::IRQ_DONE]), 48'h1);
      chk(48'(irq), 48'h0);
      wr(arv_pkg::OFF_IRQCLR, 8'h03);
      $display("test opcode %0d done", k);
    end
    slow <= 1'b0;
    run28(arv_pkg::CMD_VERIFY, 8'he0, 8'h00, 8'h00, 8'h00, 8'h00);
    chk(48'(ackCount - n0), 48'd256);
    chk(lastReq.lba, 48'h0000_0000_00ff);
    $display("test zero count done");
    // failing sector in mid-run
    wr(arv_pkg::OFF_IRQEN, 8'h02);
    failEn  <= 1'b1;
    failLba <= 48'h0000_0000_0052;
    run28(arv_pkg::CMD_VERIFY, 8'he0, 8'h05, 8'h50, 8'h00, 8'h00);
    chk(48'(ackCount - n0), 48'd3);
    rdc(arv_pkg::OFF_SECCNT, 8'h03);
    rdc(arv_pkg::OFF_SECNUM, 8'h52);
    rdc(arv_pkg::OFF_CMDSTAT, 8'h51);
    rdc(arv_pkg::OFF_ERRFEAT, 8'h40);
    chk(48'(irq), 48'h1);
    wr(arv_pkg::OFF_IRQCLR, 8'h03);
    rd(arv_pkg::OFF_IRQSTAT, rv);
    chk(48'(rv[arv_pkg::IRQ_FAIL]), 48'h0);
    chk(48'(irq), 48'h0);
    failEn <= 1'b0;
    $display("test uncorrectable done");
    // extended form: previous byte first, device/head without the lba bit
    n0 = ackCount;
    wr(arv_pkg::OFF_SECCNT, 8'h00);
    wr(arv_pkg::OFF_SECCNT, 8'h02);
    wr(arv_pkg::OFF_SECNUM, 8'h33);
    wr(arv_pkg::OFF_SECNUM, 8'hf0);
    wr(arv_pkg::OFF_CYLLO, 8'h44);
    wr(arv_pkg::OFF_CYLLO, 8'h22);
    wr(arv_pkg::OFF_CYLHI, 8'h55);
    wr(arv_pkg::OFF_CYLHI, 8'h66);
    wr(arv_pkg::OFF_DEVHEAD, 8'ha0);
    wr(arv_pkg::OFF_CMDSTAT, arv_pkg::CMD_VERIFY_EXT);
    wait_done();
    chk(48'(ackCount - n0), 48'd2);
    chk(lastReq.lba, 48'h5544_3366_22f1);
    chk(48'(lastReq.lbaMode), 48'h1);
    rdc(arv_pkg::OFF_SECNUM, 8'hf1);
    // high-order byte readback of the extended result
    wr(arv_pkg::OFF_CTRL, 8'h80);
    rdc(arv_pkg::OFF_SECNUM, 8'h33);
    rdc(arv_pkg::OFF_CYLHI, 8'h55);
    rdc(arv_pkg::OFF_SECCNT, 8'h00);
    wr(arv_pkg::OFF_CTRL, 8'h00);
    $display("test extended done");
    // geometry addressing
    run28(arv_pkg::CMD_VERIFY_NR, 8'ha3, 8'h02, 8'h10, 8'h02, 8'h01);
    chk(48'(lastReq.sec), 48'h11);
    chk(48'(lastReq.cyl), 48'h0102);
    chk(48'(lastReq.head), 48'h3);
    chk(48'(lastReq.lbaMode), 48'h0);
    rdc(arv_pkg::OFF_SECNUM, 8'h11);
    rdc(arv_pkg::OFF_CYLLO, 8'h02);
    rd(arv_pkg::OFF_DEVHEAD, rv);
    chk(48'(rv[3:0]), 48'h3);
    chk(48'(dataSeen), 48'h0);
    $display("test geometry done");
    end_of_test();
  end
endmodule // test_arv_verify
